/* rtl/tcrb_pkg.sv */
package tcrb_pkg;
  localparam logic [7:0] ADDR_IRQ_EN = 8'hA8;
  localparam logic [7:0] ADDR_IRQ_PRI = 8'hB8;
  localparam logic [7:0] ADDR_CTRL = 8'hC8;
  localparam logic [7:0] ADDR_RLD_LO = 8'hCA;
  localparam logic [7:0] ADDR_RLD_HI = 8'hCB;
  localparam logic [7:0] ADDR_CNT_LO = 8'hCC;
  localparam logic [7:0] ADDR_CNT_HI = 8'hCD;
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_T2_EN = 5;
  localparam int BIT_T2_PRI = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [7:0] IRQ_VECTOR = 8'h2B;
  localparam logic [7:0] RD_ZERO = 8'h00;

  typedef struct packed {
    logic overflowFlag;
    logic extEdgeFlag;
    logic rxBaudSelect;
    logic txBaudSelect;
    logic triggerEnable;
    logic runControl;
    logic counterSelect;
    logic captureReloadSelect;
  } tcrb_ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wrEn;
    logic rdEn;
  } tcrb_sfr_req_t;

  typedef struct packed {
    tcrb_ctrl_t ctrl;
    logic [15:0] reload;
    logic [15:0] count;
    logic globalIrqEnable;
    logic timerTwoIrqEnable;
    logic timerTwoPriority;
    logic [2:0] extCountSync;
    logic [2:0] triggerSync;
    logic [7:0] tickCnt;
    logic [7:0] rdData;
    logic irqReq;
    logic irqHigh;
    logic rxBaudTick;
    logic txBaudTick;
  } tcrb_state_t;
endpackage

/* rtl/tcrb_top.sv */
`timescale 1ns/1ps
// Summary of operation
// - counter select 1 counts external pin falling edges, 0 counts internal ticks
// - auto-reload mode sets overflow flag on every overflow
// - reload copies the 16-bit reload/capture value into the count bytes
// - trigger edge with enable reloads in auto-reload mode while running, besides overflow reload
// - capture mode wraps freely on overflow and sets overflow flag
// - capture mode trigger edge while running copies count into reload/capture registers
// - trigger enable 0 ignores trigger edges entirely
// - either baud select bit with run makes block the baud generator
// - baud mode ignores capture select and reloads on every overflow
// - receive baud select picks this overflow or timer1 overflow for receiver
// - transmit baud select picks this overflow or timer1 overflow for transmitter
// - overflow flag never set by overflow while a baud select bit is 1
// - enabled trigger falling edge sets external-edge flag, software clears it
// - enabled trigger edge requests interrupt through the external-edge flag
// - both flags share vector 2B priority 6; edge flag leaves overflow flag
// - interrupt reaches processor only with own enable and global enable
// - software writes set or clear both flags like hardware
// - control bits 7..0 as listed, reset value zero
// - uart modes 1 and 3 take bit rate from selected overflow source
module tcrb_top
  import tcrb_pkg::*;
#(
  parameter int TICK_DIV = 1
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire tcrb_sfr_req_t sfrReq,
  input wire logic extCountPin,
  input wire logic triggerPin,
  input wire logic timer1Overflow,
  output logic [7:0] sfrRdData,
  output logic irqReq,
  output logic irqHighPriority,
  output logic rxBaudTick,
  output logic txBaudTick
);
  localparam logic [7:0] TICK_LAST = 8'(TICK_DIV - 1);

  tcrb_state_t st_r;
  tcrb_state_t st_nxt;

  logic machineTick;
  logic extFall;
  logic trigFall;
  logic baudMode;
  logic advance;
  logic overflow;
  logic trigEvent;
  logic reloadEvent;
  logic captureEvent;
  logic wrCtrl;
  logic wrCntLo;
  logic wrCntHi;
  logic wrRldLo;
  logic wrRldHi;
  logic [15:0] cntInc;

  assign machineTick = (st_r.tickCnt == TICK_LAST);
  // only the second and third stages feed the edge detect
  assign extFall = st_r.extCountSync[2] & ~st_r.extCountSync[1];
  assign trigFall = st_r.triggerSync[2] & ~st_r.triggerSync[1];
  assign baudMode = st_r.ctrl.rxBaudSelect | st_r.ctrl.txBaudSelect;
  assign advance = st_r.ctrl.runControl &
                   (st_r.ctrl.counterSelect ? extFall : machineTick);
  assign overflow = advance & (st_r.count == CNT_MAX);
  assign trigEvent = trigFall & st_r.ctrl.triggerEnable;
  assign reloadEvent = st_r.ctrl.runControl & ~baudMode & ~st_r.ctrl.captureReloadSelect &
                       trigEvent;
  assign captureEvent = st_r.ctrl.runControl & ~baudMode & st_r.ctrl.captureReloadSelect &
                        trigEvent;
  assign wrCtrl = sfrReq.wrEn & (sfrReq.addr == ADDR_CTRL);
  assign wrCntLo = sfrReq.wrEn & (sfrReq.addr == ADDR_CNT_LO);
  assign wrCntHi = sfrReq.wrEn & (sfrReq.addr == ADDR_CNT_HI);
  assign wrRldLo = sfrReq.wrEn & (sfrReq.addr == ADDR_RLD_LO);
  assign wrRldHi = sfrReq.wrEn & (sfrReq.addr == ADDR_RLD_HI);
  assign cntInc = st_r.count + 16'h0001;

  always_comb begin
    st_nxt = st_r;
    st_nxt.extCountSync = {st_r.extCountSync[1:0], extCountPin};
    st_nxt.triggerSync = {st_r.triggerSync[1:0], triggerPin};
    st_nxt.tickCnt = machineTick ? 8'h00 : st_r.tickCnt + 8'h01;

    // counter: overflow reloads unless capture mode outside baud operation
    if (overflow && (baudMode || !st_r.ctrl.captureReloadSelect)) begin
      st_nxt.count = st_r.reload;
    end else if (reloadEvent) begin
      st_nxt.count = st_r.reload;
    end else if (advance) begin
      st_nxt.count = cntInc;
    end
    // software write beats the hardware update of the same byte
    if (wrCntLo) begin
      st_nxt.count[7:0] = sfrReq.wrData;
    end
    if (wrCntHi) begin
      st_nxt.count[15:8] = sfrReq.wrData;
    end

    if (captureEvent) begin
      st_nxt.reload = st_r.count;
    end
    if (wrRldLo) begin
      st_nxt.reload[7:0] = sfrReq.wrData;
    end
    if (wrRldHi) begin
      st_nxt.reload[15:8] = sfrReq.wrData;
    end

    if (wrCtrl) begin
      st_nxt.ctrl = tcrb_ctrl_t'(sfrReq.wrData);
    end
    // hardware set wins over a clearing write in the same cycle
    if (overflow && !baudMode) begin
      st_nxt.ctrl.overflowFlag = 1'b1;
    end
    if (trigEvent) begin
      st_nxt.ctrl.extEdgeFlag = 1'b1;
    end

    if (sfrReq.wrEn && sfrReq.addr == ADDR_IRQ_EN) begin
      st_nxt.globalIrqEnable = sfrReq.wrData[BIT_GLOBAL_EN];
      st_nxt.timerTwoIrqEnable = sfrReq.wrData[BIT_T2_EN];
    end
    if (sfrReq.wrEn && sfrReq.addr == ADDR_IRQ_PRI) begin
      st_nxt.timerTwoPriority = sfrReq.wrData[BIT_T2_PRI];
    end

    st_nxt.irqReq = st_r.globalIrqEnable & st_r.timerTwoIrqEnable &
                    (st_r.ctrl.overflowFlag | st_r.ctrl.extEdgeFlag);
    st_nxt.irqHigh = st_r.timerTwoPriority;
    st_nxt.rxBaudTick = st_r.ctrl.rxBaudSelect ? overflow : timer1Overflow;
    st_nxt.txBaudTick = st_r.ctrl.txBaudSelect ? overflow : timer1Overflow;

    st_nxt.rdData = RD_ZERO;
    if (sfrReq.rdEn) begin
      unique case (sfrReq.addr)
        ADDR_CTRL: st_nxt.rdData = st_r.ctrl;
        ADDR_RLD_LO: st_nxt.rdData = st_r.reload[7:0];
        ADDR_RLD_HI: st_nxt.rdData = st_r.reload[15:8];
        ADDR_CNT_LO: st_nxt.rdData = st_r.count[7:0];
        ADDR_CNT_HI: st_nxt.rdData = st_r.count[15:8];
        ADDR_IRQ_EN: begin
          st_nxt.rdData[BIT_GLOBAL_EN] = st_r.globalIrqEnable;
          st_nxt.rdData[BIT_T2_EN] = st_r.timerTwoIrqEnable;
        end
        ADDR_IRQ_PRI: st_nxt.rdData[BIT_T2_PRI] = st_r.timerTwoPriority;
        default: st_nxt.rdData = RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r <= '0;
      st_r.ctrl <= tcrb_ctrl_t'(CTRL_RESET);
      st_r.count <= CNT_RESET;
      st_r.reload <= CNT_RESET;
      // pins idle high so no false edge right after reset
      st_r.extCountSync <= 3'h7;
      st_r.triggerSync <= 3'h7;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sfrRdData = st_r.rdData;
  assign irqReq = st_r.irqReq;
  assign irqHighPriority = st_r.irqHigh;
  assign rxBaudTick = st_r.rxBaudTick;
  assign txBaudTick = st_r.txBaudTick;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_ovf_flag;
    overflow && !baudMode |=> st_r.ctrl.overflowFlag;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag missed");

  property p_baud_no_flag;
    overflow && baudMode && !wrCtrl |=> st_r.ctrl.overflowFlag == $past(st_r.ctrl.overflowFlag);
  endproperty
  a_baud_no_flag: assert property (p_baud_no_flag) else $error("flag set in baud mode");

  property p_reload;
    overflow && (baudMode || !st_r.ctrl.captureReloadSelect) && !wrCntLo && !wrCntHi
      |=> st_r.count == $past(st_r.reload);
  endproperty
  a_reload: assert property (p_reload) else $error("reload on overflow wrong");

  property p_capture;
    captureEvent && !wrRldLo && !wrRldHi |=> st_r.reload == $past(st_r.count);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_stopped;
    !st_r.ctrl.runControl && !wrCntLo && !wrCntHi |=> st_r.count == $past(st_r.count);
  endproperty
  a_stopped: assert property (p_stopped) else $error("count moved while stopped");

  property p_trig_ignored;
    trigFall && !st_r.ctrl.triggerEnable && !wrCtrl
      |=> st_r.ctrl.extEdgeFlag == $past(st_r.ctrl.extEdgeFlag);
  endproperty
  a_trig_ignored: assert property (p_trig_ignored) else $error("disabled edge acted");

  property p_edge_flag;
    trigEvent |=> st_r.ctrl.extEdgeFlag;
  endproperty
  a_edge_flag: assert property (p_edge_flag) else $error("edge flag missed");

  property p_irq;
    (st_r.ctrl.overflowFlag || st_r.ctrl.extEdgeFlag) && st_r.globalIrqEnable &&
      st_r.timerTwoIrqEnable |=> irqReq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_rx_tick;
    overflow && st_r.ctrl.rxBaudSelect |=> rxBaudTick;
  endproperty
  a_rx_tick: assert property (p_rx_tick) else $error("receive tick missed");

  property p_tx_tick;
    !st_r.ctrl.txBaudSelect && timer1Overflow |=> txBaudTick;
  endproperty
  a_tx_tick: assert property (p_tx_tick) else $error("transmit tick missed");

  property p_trig_reload;
    reloadEvent && !wrCntLo && !wrCntHi |=> st_r.count == $past(st_r.reload);
  endproperty
  a_trig_reload: assert property (p_trig_reload) else $error("trigger reload wrong");

  // capture mode must wrap to zero, never take the reload value
  property p_capture_wrap;
    overflow && st_r.ctrl.captureReloadSelect && !baudMode && !wrCntLo && !wrCntHi
      |=> st_r.count == '0;
  endproperty
  a_capture_wrap: assert property (p_capture_wrap) else $error("capture overflow wrong");

  property p_baud_trig;
    trigEvent && baudMode && !advance && !wrCntLo && !wrCntHi |=> $stable(st_r.count);
  endproperty
  a_baud_trig: assert property (p_baud_trig) else $error("trigger reloaded in baud mode");

  property p_trig_ignored_cnt;
    trigFall && !st_r.ctrl.triggerEnable && !advance && !wrCntLo && !wrCntHi &&
      !wrRldLo && !wrRldHi |=> $stable(st_r.count) && $stable(st_r.reload);
  endproperty
  a_trig_ignored_cnt: assert property (p_trig_ignored_cnt) else $error("disabled edge moved data");

  property p_edge_keeps_ovf;
    trigEvent && !overflow && !wrCtrl
      |=> st_r.ctrl.overflowFlag == $past(st_r.ctrl.overflowFlag);
  endproperty
  a_edge_keeps_ovf: assert property (p_edge_keeps_ovf) else $error("edge touched overflow flag");

  // flags are sticky: only a software write may drop them
  property p_ovf_sticky;
    st_r.ctrl.overflowFlag && !wrCtrl |=> st_r.ctrl.overflowFlag;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag dropped");

  property p_edge_sticky;
    st_r.ctrl.extEdgeFlag && !wrCtrl |=> st_r.ctrl.extEdgeFlag;
  endproperty
  a_edge_sticky: assert property (p_edge_sticky) else $error("edge flag dropped");

  property p_sw_write;
    wrCtrl && !overflow && !trigEvent |=> st_r.ctrl == $past(sfrReq.wrData);
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("control write lost");

  property p_irq_off;
    !(st_r.globalIrqEnable && st_r.timerTwoIrqEnable) |=> !irqReq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt not masked");

  property p_pri;
    1'b1 |=> irqHighPriority == $past(st_r.timerTwoPriority);
  endproperty
  a_pri: assert property (p_pri) else $error("priority level wrong");

  // internal ticks must not move the count in counter mode
  property p_ext_only;
    st_r.ctrl.counterSelect && !extFall && !reloadEvent && !wrCntLo && !wrCntHi
      |=> $stable(st_r.count);
  endproperty
  a_ext_only: assert property (p_ext_only) else $error("count moved without pin edge");

  property p_timer_inc;
    advance && !overflow && !reloadEvent && !wrCntLo && !wrCntHi
      |=> st_r.count == $past(st_r.count) + 16'h0001;
  endproperty
  a_timer_inc: assert property (p_timer_inc) else $error("count step wrong");

  property p_rx_t1;
    !st_r.ctrl.rxBaudSelect && timer1Overflow |=> rxBaudTick;
  endproperty
  a_rx_t1: assert property (p_rx_t1) else $error("receive timer1 tick missed");

  property p_tx_ovf;
    overflow && st_r.ctrl.txBaudSelect |=> txBaudTick;
  endproperty
  a_tx_ovf: assert property (p_tx_ovf) else $error("transmit overflow tick missed");

  c_reload: cover property (overflow && !st_r.ctrl.captureReloadSelect && !baudMode);
  c_trig_reload: cover property (reloadEvent);
  c_capture: cover property (captureEvent);
  c_baud: cover property (overflow && baudMode);
  c_irq: cover property (irqReq);
endmodule

/* test/tcrb_pin_src.sv */
`timescale 1ns/1ps
// far-side pin sources; both pins idle high like the preset sync stages
module tcrb_pin_src (
  input wire logic ref_clk,
  output logic extCountPin,
  output logic triggerPin,
  output logic timer1Overflow
);
  initial begin
    extCountPin = 1'b1;
    triggerPin = 1'b1;
    timer1Overflow = 1'b0;
  end
  // 3 low and 6 high clocks keep each level past the 2-clock minimum
  task automatic fall(input bit trig);
    @(negedge ref_clk);
    if (trig) triggerPin = 1'b0;
    else extCountPin = 1'b0;
    repeat (3) @(negedge ref_clk);
    extCountPin = 1'b1;
    triggerPin = 1'b1;
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic pulseT1();
    @(negedge ref_clk);
    timer1Overflow = 1'b1;
    @(negedge ref_clk);
    timer1Overflow = 1'b0;
  endtask
endmodule

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import tcrb_pkg::*;
  logic ref_clk;
  logic reset;
  tcrb_sfr_req_t sfrReq;
  logic extCountPin, triggerPin, timer1Overflow;
  logic [7:0] sfrRdData;
  logic irqReq, irqHighPriority, rxBaudTick, txBaudTick;
  int n_errors = 0;
  int total_checks = 0;
  int rxCnt = 0;
  int txCnt = 0;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (rxBaudTick === 1'b1) rxCnt <= rxCnt + 1;
    if (txBaudTick === 1'b1) txCnt <= txCnt + 1;
  end
  tcrb_top dut (.ref_clk(ref_clk), .reset(reset), .sfrReq(sfrReq), .extCountPin(extCountPin),
    .triggerPin(triggerPin), .timer1Overflow(timer1Overflow), .sfrRdData(sfrRdData),
    .irqReq(irqReq), .irqHighPriority(irqHighPriority), .rxBaudTick(rxBaudTick),
    .txBaudTick(txBaudTick));
  tcrb_pin_src pins (.ref_clk(ref_clk), .extCountPin(extCountPin), .triggerPin(triggerPin),
    .timer1Overflow(timer1Overflow));
  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfrReq = '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
    @(negedge ref_clk);
    sfrReq = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    sfrReq = '{addr: a, wrData: 8'h00, wrEn: 1'b0, rdEn: 1'b1};
    @(negedge ref_clk);
    sfrReq = '0;
    chk($sformatf("reg %h", a), sfrRdData, exp);
  endtask
  task automatic rd16(input logic [7:0] a, input logic [15:0] exp);
    rd(a, exp[7:0]);
    rd(8'(a + 8'h01), exp[15:8]);
  endtask
  // control written last so nothing moves while the bytes load
  task automatic setup(input logic [15:0] cnt, input logic [15:0] rld, input logic [7:0] c);
    wr(ADDR_CNT_LO, cnt[7:0]);
    wr(ADDR_CNT_HI, cnt[15:8]);
    wr(ADDR_RLD_LO, rld[7:0]);
    wr(ADDR_RLD_HI, rld[15:8]);
    wr(ADDR_CTRL, c);
  endtask
  task automatic t_reset();
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_IRQ_EN, 8'h00);
    rd(ADDR_IRQ_PRI, 8'h00);
    rd(8'hC9, RD_ZERO);
    chk("irqReq", {7'h00, irqReq}, 8'h00);
  endtask
  task automatic t_reload();
    setup(16'hFFFF, 16'h1234, 8'h06);
    pins.fall(1'b0);
    rd16(ADDR_CNT_LO, 16'h1234);
    repeat (5) @(negedge ref_clk);
    rd(ADDR_CTRL, 8'h86);
    wr(ADDR_CTRL, 8'h06);
    rd(ADDR_CTRL, 8'h06);
    setup(16'h0050, 16'hBEEF, 8'h0E);
    pins.fall(1'b1);
    rd16(ADDR_CNT_LO, 16'hBEEF);
    rd(ADDR_CTRL, 8'h4E);
    wr(ADDR_IRQ_EN, 8'hA0);
    repeat (2) @(negedge ref_clk);
    chk("irqReq", {7'h00, irqReq}, 8'h01);
    wr(ADDR_IRQ_EN, 8'h80);
    repeat (2) @(negedge ref_clk);
    chk("irqReq", {7'h00, irqReq}, 8'h00);
  endtask
  task automatic t_capture();
    setup(16'hABCD, 16'h0000, 8'h0F);
    pins.fall(1'b1);
    rd16(ADDR_RLD_LO, 16'hABCD);
    rd16(ADDR_CNT_LO, 16'hABCD);
    setup(16'hFFFF, 16'h5555, 8'h0F);
    pins.fall(1'b0);
    rd16(ADDR_CNT_LO, 16'h0000);
    rd(ADDR_CTRL, 8'h8F);
  endtask
  task automatic t_ignore();
    setup(16'h0050, 16'h7777, 8'h07);
    pins.fall(1'b1);
    rd16(ADDR_CNT_LO, 16'h0050);
    rd16(ADDR_RLD_LO, 16'h7777);
    rd(ADDR_CTRL, 8'h07);
    setup(16'h0050, 16'h7777, 8'h0A);
    pins.fall(1'b0);
    pins.fall(1'b1);
    rd16(ADDR_CNT_LO, 16'h0050);
    rd(ADDR_CTRL, 8'h4A);
  endtask
  task automatic t_baud();
    setup(16'hFFFF, 16'h1234, 8'h37);
    pins.fall(1'b0);
    rd16(ADDR_CNT_LO, 16'h1234);
    rd(ADDR_CTRL, 8'h37);
    chk("ticks", 8'(rxCnt * 16 + txCnt), 8'h11);
    setup(16'hFFFF, 16'h1234, 8'h26);
    pins.fall(1'b0);
    pins.pulseT1();
    repeat (3) @(negedge ref_clk);
    chk("ticks", 8'(rxCnt * 16 + txCnt), 8'h22);
    setup(16'hFFFF, 16'h1234, 8'h1E);
    pins.fall(1'b0);
    pins.pulseT1();
    wr(ADDR_RLD_LO, 8'h00);
    pins.fall(1'b1);
    chk("ticks", 8'(rxCnt * 16 + txCnt), 8'h33);
    rd16(ADDR_CNT_LO, 16'h1234);
    rd(ADDR_CTRL, 8'h5E);
  endtask
  task automatic t_irq();
    wr(ADDR_CTRL, 8'h80);
    wr(ADDR_IRQ_EN, 8'hA0);
    repeat (2) @(negedge ref_clk);
    chk("irqReq", {7'h00, irqReq}, 8'h01);
    wr(ADDR_IRQ_PRI, 8'h20);
    repeat (2) @(negedge ref_clk);
    chk("irqHigh", {7'h00, irqHighPriority}, 8'h01);
    rd(ADDR_IRQ_PRI, 8'h20);
    wr(ADDR_IRQ_PRI, 8'h00);
    repeat (2) @(negedge ref_clk);
    chk("irqHigh", {7'h00, irqHighPriority}, 8'h00);
  endtask
  // 16 internal ticks from FFF0; the stop write meets the overflow edge
  task automatic t_timer();
    setup(16'hFFF0, 16'h1234, 8'h04);
    repeat (14) @(negedge ref_clk);
    wr(ADDR_CTRL, 8'h00);
    rd16(ADDR_CNT_LO, 16'h1234);
    rd(ADDR_CTRL, 8'h80);
  endtask
  task automatic t_midreset();
    @(negedge ref_clk);
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    rd(ADDR_CTRL, CTRL_RESET);
    rd16(ADDR_CNT_LO, CNT_RESET);
    rd(ADDR_IRQ_EN, 8'h00);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    sfrReq = '0;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    t_reset();
    t_reload();
    t_capture();
    t_ignore();
    t_baud();
    t_irq();
    t_timer();
    t_midreset();
    print_verdict();
  end
endmodule
